// >>> uart_pin_strap_config.sv
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "strap_map.svh"

// Notes on behaviour
// - Clear-to-send shown at status bit 4.
// - Request-to-send pin low when ready to send.
// - Channel A request strap sets port select.
// - Channel B request strap enables watchdog, count 0x0A.
// - Channel A terminal strap sets default-clear bit.
// - Channel A output strap enables keyboard controller.
// - Channel B output strap sets bit six.
// - Terminal-ready pin low when ready to talk.
// - Serial input pin received per channel.
// - Serial output driven only after reset ends.
module uart_pin_strap_config
	import strap_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [`ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [`ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic      [31:0]       rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              clear_to_send_a_n,
	input  wire logic              clear_to_send_b_n,
	input  wire logic              set_ready_a_n,
	input  wire logic              set_ready_b_n,
	input  wire logic              carrier_detect_a_n,
	input  wire logic              carrier_detect_b_n,
	input  wire logic              ring_indicate_a_n,
	input  wire logic              ring_indicate_b_n,
	input  wire logic              serial_in_a,
	input  wire logic              serial_in_b,
	input  wire logic              request_send_a_n_i,
	output logic                   request_send_a_n_o,
	output logic                   request_send_a_n_oe,
	input  wire logic              request_send_b_n_i,
	output logic                   request_send_b_n_o,
	output logic                   request_send_b_n_oe,
	input  wire logic              terminal_ready_a_n_i,
	output logic                   terminal_ready_a_n_o,
	output logic                   terminal_ready_a_n_oe,
	output logic                   terminal_ready_b_n_o,
	output logic                   terminal_ready_b_n_oe,
	input  wire logic              serial_out_a_i,
	output logic                   serial_out_a_o,
	output logic                   serial_out_a_oe,
	input  wire logic              serial_out_b_i,
	output logic                   serial_out_b_o,
	output logic                   serial_out_b_oe,
	output logic                   cfg_port_addr_sel,
	output logic                   watchdog_enable,
	output logic      [7:0]        watchdog_count,
	output logic                   default_clear,
	output logic                   keyboard_ctrl_enable_bit,
	output logic                   cfg_bit_six
);

	// Address decode, shared by the write and read paths
	function automatic reg_sel_t decode(input logic [`ADDR_W-1:0] a);
		reg_sel_t s;
		unique case (a)
			`OFF_GC24:   s = SEL_GC24;
			`OFF_GC26:   s = SEL_GC26;
			`OFF_ACT:    s = SEL_ACT;
			`OFF_WDC:    s = SEL_WDC;
			`OFF_CTRL_A: s = SEL_CTRL_A;
			`OFF_CTRL_B: s = SEL_CTRL_B;
			`OFF_STS_A:  s = SEL_STS_A;
			`OFF_STS_B:  s = SEL_STS_B;
			default:     s = SEL_NONE;
		endcase
		return s;
	endfunction : decode

	// Byte registers live in lane 0; other lanes are ignored
	function automatic cfg_byte_t merge8(input cfg_byte_t old,
		input logic [31:0] d, input logic [3:0] be);
		return be[0] ? d[7:0] : old;
	endfunction : merge8

	// Pin inputs, gathered for one synchroniser
	logic [`SYNC_W-1:0]  pins_raw;      // Raw pin levels
	logic [`SYNC_W-1:0]  pins_s;        // Synchronised levels
	logic [`STRAP_W-1:0] strap_q;       // Frozen strap levels
	logic                strap_load;    // Pulse after release

	// Configuration and channel registers
	cfg_byte_t           gc24_q;        // Global config 24
	cfg_byte_t           gc26_q;        // Global config 26
	cfg_byte_t           act_q;         // Device activate
	cfg_byte_t           wdc_q;         // Watchdog count
	cfg_byte_t           ctrl_q [2];    // Modem control, A and B
	logic [`MODEM_W-1:0] line_now [2];  // Modem lines, active high
	logic [`MODEM_W-1:0] line_prev_q [2]; // Last seen modem lines
	logic [`MODEM_W-1:0] delta_q [2];   // Sticky change flags
	logic [`MODEM_W-1:0] delta_set [2]; // Change seen this cycle
	logic [1:0]          sts_clr;       // Status read taken
	logic [31:0]         sts_word [2];  // Status read value

	// Bus slave state
	logic                aw_hold_q;     // Write address held
	logic                w_hold_q;      // Write data held
	logic [`ADDR_W-1:0]  waddr_q;       // Held write address
	logic [31:0]         wdata_q;       // Held write data
	logic [3:0]          wstrb_q;       // Held write strobes
	logic                aw_take;       // Address handshake
	logic                w_take;        // Data handshake
	logic                wr_fire;       // Both halves present
	logic                aw_hold_d;     // Next address hold
	logic                w_hold_d;      // Next data hold
	logic                bvalid_d;      // Next response valid
	logic                ar_take;       // Read handshake
	logic                rvalid_d;      // Next read valid
	reg_sel_t            wsel;          // Decoded write target
	reg_sel_t            rsel;          // Decoded read target
	logic [31:0]         rd_word;       // Read mux output

	// Pins cross into the clock domain before anything reads them
	assign pins_raw = {serial_out_b_i, serial_out_a_i,
		terminal_ready_a_n_i, request_send_b_n_i, request_send_a_n_i,
		serial_in_b, serial_in_a, ring_indicate_b_n, ring_indicate_a_n,
		carrier_detect_b_n, carrier_detect_a_n, set_ready_b_n,
		set_ready_a_n, clear_to_send_b_n, clear_to_send_a_n};

	pin_sync #(
		.W(`SYNC_W)
	) u_sync (
		.aclk   (aclk),
		.async_i(pins_raw),
		.sync_o (pins_s)
	);

	// Strap capture sits on the shared output pins
	strap_capture u_straps (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.strap_pins(pins_s[14:10]),
		.strap_q   (strap_q),
		.load_q    (strap_load)
	);

	// Modem lines per channel, turned active high for software
	always_comb begin
		for (int ch = 0; ch < 2; ch++) begin
			line_now[ch] = ~{pins_s[4+ch], pins_s[6+ch],
				pins_s[2+ch], pins_s[ch]};
			delta_set[ch][0] = line_now[ch][0] ^ line_prev_q[ch][0];
			delta_set[ch][1] = line_now[ch][1] ^ line_prev_q[ch][1];
			// Ring flag only on the end of a ring pulse
			delta_set[ch][2] = line_prev_q[ch][2] & ~line_now[ch][2];
			delta_set[ch][3] = line_now[ch][3] ^ line_prev_q[ch][3];
			sts_word[ch] = {23'h000000, pins_s[8+ch], line_now[ch],
				delta_q[ch]};
		end
	end

	// Status reads clear the change flags of that channel
	assign sts_clr[0] = ar_take && (rsel == SEL_STS_A);
	assign sts_clr[1] = ar_take && (rsel == SEL_STS_B);

	// Change flags: a new event wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int ch = 0; ch < 2; ch++) begin
				line_prev_q[ch] <= 4'h0;
				delta_q[ch]     <= 4'h0;
			end
		end else begin
			for (int ch = 0; ch < 2; ch++) begin
				line_prev_q[ch] <= line_now[ch];
				delta_q[ch] <= (delta_q[ch] & ~{4{sts_clr[ch]}})
					| delta_set[ch];
			end
		end
	end

	// Write channel bookkeeping
	assign aw_take   = awvalid && awready;
	assign w_take    = wvalid && wready;
	assign wr_fire   = aw_hold_q && w_hold_q && !bvalid;
	assign aw_hold_d = (aw_hold_q || aw_take) && !wr_fire;
	assign w_hold_d  = (w_hold_q || w_take) && !wr_fire;
	assign bvalid_d  = wr_fire || (bvalid && !bready);
	assign wsel      = decode(waddr_q);

	// Write address and data are taken in either order and held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q  <= w_hold_d;
			// Each ready only while its own half is not held and no answer pending
			awready   <= !aw_hold_d && !bvalid_d;
			wready    <= !w_hold_d && !bvalid_d;
			bvalid    <= bvalid_d;
			if (wr_fire) begin
				bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// Payload capture, no reset needed on data
	always_ff @(posedge aclk) begin
		if (aw_take) begin
			waddr_q <= awaddr;
		end
		if (w_take) begin
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end
	end

	// Configuration bytes: straps seed them, software may rewrite
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gc24_q <= `CFG_RST;
			gc26_q <= `CFG_RST;
			act_q  <= `CFG_RST;
			wdc_q  <= `CFG_RST;
		end else if (strap_load) begin
			gc24_q <= `CFG_RST;
			gc26_q <= `CFG_RST;
			act_q  <= `CFG_RST;
			gc26_q[`GC26_PORT_BIT] <= strap_q[`STRAP_PORT];
			act_q[`ACT_WDOG_BIT] <= strap_q[`STRAP_WDOG];
			// Watchdog count only seeded when the strap enables it
			wdc_q <= strap_q[`STRAP_WDOG] ? `WDOG_LOAD
				: `CFG_RST;
			gc24_q[`GC24_DEFCLR_BIT] <= strap_q[`STRAP_DEFCLR];
			gc24_q[`GC24_KBC_BIT] <= strap_q[`STRAP_KBC];
			gc24_q[`GC24_BIT6_BIT] <= strap_q[`STRAP_BIT6];
		end else if (wr_fire) begin
			unique case (wsel)
				SEL_GC24: gc24_q <= merge8(gc24_q, wdata_q, wstrb_q);
				SEL_GC26: gc26_q <= merge8(gc26_q, wdata_q, wstrb_q);
				SEL_ACT:  act_q  <= merge8(act_q, wdata_q, wstrb_q);
				SEL_WDC:  wdc_q  <= merge8(wdc_q, wdata_q, wstrb_q);
				// Other targets do not touch these bytes
				default: ;
			endcase
		end
	end

	// Channel control bytes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q[0] <= `CTRL_RST;
			ctrl_q[1] <= `CTRL_RST;
		end else if (wr_fire) begin
			if (wsel == SEL_CTRL_A) begin
				ctrl_q[0] <= merge8(ctrl_q[0], wdata_q, wstrb_q);
			end
			if (wsel == SEL_CTRL_B) begin
				ctrl_q[1] <= merge8(ctrl_q[1], wdata_q, wstrb_q);
			end
		end
	end

	// Read channel
	assign ar_take  = arvalid && arready;
	assign rvalid_d = ar_take || (rvalid && !rready);
	assign rsel     = decode(araddr);

	// Read mux; unmapped reads return zero
	always_comb begin
		rd_word = 32'h00000000;
		unique case (rsel)
			SEL_GC24:   rd_word[7:0] = gc24_q;
			SEL_GC26:   rd_word[7:0] = gc26_q;
			SEL_ACT:    rd_word[7:0] = act_q;
			SEL_WDC:    rd_word[7:0] = wdc_q;
			SEL_CTRL_A: rd_word[7:0] = ctrl_q[0];
			SEL_CTRL_B: rd_word[7:0] = ctrl_q[1];
			SEL_STS_A:  rd_word = sts_word[0];
			SEL_STS_B:  rd_word = sts_word[1];
			default:    rd_word = 32'h00000000;
		endcase
	end

	// One read at a time; data held until rready
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= RESP_OKAY;
		end else begin
			arready <= !rvalid_d;
			rvalid  <= rvalid_d;
			if (ar_take) begin
				rdata <= rd_word;
				rresp <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end

	// Shared pins stay undriven in reset so straps can be read.
	// Drivers turn on one cycle after the straps have frozen.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			request_send_a_n_oe   <= 1'b0;
			request_send_b_n_oe   <= 1'b0;
			terminal_ready_a_n_oe <= 1'b0;
			terminal_ready_b_n_oe <= 1'b0;
			serial_out_a_oe       <= 1'b0;
			serial_out_b_oe       <= 1'b0;
		end else if (strap_load) begin
			request_send_a_n_oe   <= 1'b1;
			request_send_b_n_oe   <= 1'b1;
			terminal_ready_a_n_oe <= 1'b1;
			terminal_ready_b_n_oe <= 1'b1;
			serial_out_a_oe       <= 1'b1;
			serial_out_b_oe       <= 1'b1;
		end
	end

	// Pin levels: inactive high and line idle (mark) after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			request_send_a_n_o   <= 1'b1;
			request_send_b_n_o   <= 1'b1;
			terminal_ready_a_n_o <= 1'b1;
			terminal_ready_b_n_o <= 1'b1;
			serial_out_a_o       <= 1'b1;
			serial_out_b_o       <= 1'b1;
		end else begin
			request_send_a_n_o <= ~ctrl_q[0][`CTRL_RTS_BIT];
			request_send_b_n_o <= ~ctrl_q[1][`CTRL_RTS_BIT];
			terminal_ready_a_n_o <= ~ctrl_q[0][`CTRL_DTR_BIT];
			terminal_ready_b_n_o <= ~ctrl_q[1][`CTRL_DTR_BIT];
			serial_out_a_o <= ctrl_q[0][`CTRL_TXD_BIT];
			serial_out_b_o <= ctrl_q[1][`CTRL_TXD_BIT];
		end
	end

	// Decoded configuration, straight from the register bits
	assign cfg_port_addr_sel        = gc26_q[`GC26_PORT_BIT];
	assign watchdog_enable          = act_q[`ACT_WDOG_BIT];
	assign watchdog_count           = wdc_q;
	assign default_clear            = gc24_q[`GC24_DEFCLR_BIT];
	assign keyboard_ctrl_enable_bit = gc24_q[`GC24_KBC_BIT];
	assign cfg_bit_six              = gc24_q[`GC24_BIT6_BIT];

endmodule : uart_pin_strap_config

// >>> strap_map.svh
`ifndef STRAP_MAP_SVH
`define STRAP_MAP_SVH

// Register byte offsets on the register bus
`define OFF_GC24        8'h00
`define OFF_GC26        8'h04
`define OFF_ACT         8'h08
`define OFF_WDC         8'h0C
`define OFF_CTRL_A      8'h10
`define OFF_CTRL_B      8'h14
`define OFF_STS_A       8'h18
`define OFF_STS_B       8'h1C

// Field positions in the configuration registers
`define GC24_DEFCLR_BIT 0
`define GC24_KBC_BIT    2
`define GC24_BIT6_BIT   6
`define GC26_PORT_BIT   6
`define ACT_WDOG_BIT    0

// Field positions in the channel control register
`define CTRL_DTR_BIT    0
`define CTRL_RTS_BIT    1
`define CTRL_TXD_BIT    4

// Field positions in the channel status register
`define STS_CTS_BIT     4
`define STS_SIN_BIT     8

// Reset values
`define CFG_RST         8'h00
`define CTRL_RST        8'h10
`define WDOG_LOAD       8'h0A

// Widths and strap vector positions
`define ADDR_W          8
`define MODEM_W         4
`define SYNC_W          15
`define STRAP_W         5
`define STRAP_PORT      0
`define STRAP_WDOG      1
`define STRAP_DEFCLR    2
`define STRAP_KBC       3
`define STRAP_BIT6      4

`endif

// >>> strap_pkg.sv
package strap_pkg;

	// Register selected by an address decode
	typedef enum logic [3:0] {
		SEL_GC24   = 4'b0000,
		SEL_GC26   = 4'b0001,
		SEL_ACT    = 4'b0010,
		SEL_WDC    = 4'b0011,
		SEL_CTRL_A = 4'b0100,
		SEL_CTRL_B = 4'b0101,
		SEL_STS_A  = 4'b0110,
		SEL_STS_B  = 4'b0111,
		SEL_NONE   = 4'b1111
	} reg_sel_t;

	// Bus response codes used by the slave
	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_SLVERR = 2'b10
	} axi_resp_t;

	// One configuration byte
	typedef logic [7:0] cfg_byte_t;

endpackage : strap_pkg

// >>> pin_sync.sv
`timescale 1ns/1ps
`include "strap_map.svh"

// Two-stage synchroniser for every pin that enters the block
module pin_sync #(
	parameter int W = `SYNC_W
) (
	input  wire logic         aclk,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] stage1_q; // Only the second stage reads this

	// Plain data path, no reset needed on a synchroniser
	always_ff @(posedge aclk) begin
		stage1_q <= async_i;
		sync_o   <= stage1_q;
	end

endmodule : pin_sync

// >>> strap_capture.sv
`timescale 1ns/1ps
`include "strap_map.svh"

// Follows the strap pins during reset, freezes them at release
module strap_capture
	import strap_pkg::*;
(
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [`STRAP_W-1:0] strap_pins,
	output logic      [`STRAP_W-1:0] strap_q,
	output logic                     load_q
);

	logic in_reset_q; // High while reset held

	// Track straps while in reset; value at release edge stays
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_q <= strap_pins;
		end
	end

	// One-cycle load pulse right after the release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_reset_q <= 1'b1;
			load_q     <= 1'b0;
		end else begin
			in_reset_q <= 1'b0;
			load_q     <= in_reset_q;
		end
	end

endmodule : strap_capture

// >>> strap_checker_asserts.sv
`timescale 1ns/1ps

// Watches strap loading, pin release and bus answers
module strap_checker (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       arvalid,
	input wire logic       arready,
	input wire logic       rvalid,
	input wire logic       bvalid,
	input wire logic       bready,
	input wire logic       request_send_a_n_i,
	input wire logic       request_send_b_n_i,
	input wire logic       terminal_ready_a_n_i,
	input wire logic       serial_out_a_i,
	input wire logic       serial_out_b_i,
	input wire logic       request_send_a_n_o,
	input wire logic       terminal_ready_a_n_o,
	input wire logic       serial_out_a_oe,
	input wire logic       serial_out_b_oe,
	input wire logic       cfg_port_addr_sel,
	input wire logic       watchdog_enable,
	input wire logic [7:0] watchdog_count,
	input wire logic       default_clear,
	input wire logic       keyboard_ctrl_enable_bit,
	input wire logic       cfg_bit_six
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Pins stay released until the straps are frozen
	chk_oe_release: assert property (
		$rose(aresetn) |-> (!serial_out_a_oe && !serial_out_b_oe)[*2]
		##1 (serial_out_a_oe && serial_out_b_oe))
		else $error("shared pins driven at wrong time");
	// Strap levels are taken from the pull level during reset
	chk_port_strap: assert property (
		$rose(aresetn) |-> ##2
		cfg_port_addr_sel == $past(request_send_a_n_i, 5))
		else $error("port select strap wrong");
	chk_wdog_strap: assert property (
		$rose(aresetn) |-> ##2
		watchdog_enable == $past(request_send_b_n_i, 5) &&
		watchdog_count == ($past(request_send_b_n_i, 5) ? 8'h0A : 8'h00))
		else $error("watchdog strap or count wrong");
	chk_defclr_strap: assert property (
		$rose(aresetn) |-> ##2
		default_clear == $past(terminal_ready_a_n_i, 5))
		else $error("default clear strap wrong");
	chk_kbc_strap: assert property (
		$rose(aresetn) |-> ##2
		keyboard_ctrl_enable_bit == $past(serial_out_a_i, 5))
		else $error("keyboard strap wrong");
	chk_bit_six_strap: assert property (
		$rose(aresetn) |-> ##2 cfg_bit_six == $past(serial_out_b_i, 5))
		else $error("bit six strap wrong");
	// Handshake pins move only as a result of a register write
	chk_rts_cause: assert property (
		$changed(request_send_a_n_o) |-> bvalid || $past(bvalid))
		else $error("request pin moved without a write");
	chk_dtr_cause: assert property (
		$changed(terminal_ready_a_n_o) |-> bvalid || $past(bvalid))
		else $error("terminal pin moved without a write");
	// Bus answers: read one edge after the address, write held
	chk_read_answer: assert property (
		arvalid && arready |=> rvalid)
		else $error("read answer late");
	chk_write_hold: assert property (
		bvalid && !bready |=> bvalid)
		else $error("write response dropped");

	// Main scenarios reached
	cover property ($rose(aresetn) ##2 watchdog_enable);
	cover property (arvalid && arready ##1 rvalid);
	cover property ($fell(request_send_a_n_o));
endmodule : strap_checker

bind uart_pin_strap_config strap_checker i_chk (
	.aclk(aclk), .aresetn(aresetn), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .bvalid(bvalid), .bready(bready),
	.request_send_a_n_i(request_send_a_n_i),
	.request_send_b_n_i(request_send_b_n_i),
	.terminal_ready_a_n_i(terminal_ready_a_n_i),
	.serial_out_a_i(serial_out_a_i), .serial_out_b_i(serial_out_b_i),
	.request_send_a_n_o(request_send_a_n_o),
	.terminal_ready_a_n_o(terminal_ready_a_n_o),
	.serial_out_a_oe(serial_out_a_oe), .serial_out_b_oe(serial_out_b_oe),
	.cfg_port_addr_sel(cfg_port_addr_sel),
	.watchdog_enable(watchdog_enable), .watchdog_count(watchdog_count),
	.default_clear(default_clear), .cfg_bit_six(cfg_bit_six),
	.keyboard_ctrl_enable_bit(keyboard_ctrl_enable_bit));

// >>> modem_model.sv
`timescale 1ns/1ps

// Modem and board pulls around the serial pins
module modem_model (
	input  wire logic       aclk,
	input  wire logic [7:0] asserted,
	input  wire logic [1:0] sin,
	input  wire logic [4:0] pull_up,
	input  wire logic [4:0] pin_o,
	input  wire logic [4:0] pin_oe,
	output logic      [7:0] modem_n,
	output logic      [1:0] serial_in,
	output logic      [4:0] pin_lvl
);
	// Lines move just after an edge, low while active
	always_ff @(posedge aclk) begin
		modem_n   <= ~asserted;
		serial_in <= sin;
	end
	// Released pin falls to its pull: fitted pull-up, else low
	assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & pull_up);
endmodule : modem_model

// >>> tb.sv
`timescale 1ns/1ps
`include "strap_map.svh"

module tb import strap_pkg::*;;
	logic        aclk, aresetn;
	logic [7:0]  awaddr, araddr, asserted, modem_n, watchdog_count;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, sin, serial_in;
	logic [4:0]  pull_up, pin_o, pin_oe, pin_lvl;
	logic        dtr_b_o, dtr_b_oe, port_sel, wdog_en;
	logic        def_clr, kbc_en, bit_six;
	int          n_fail, comparisons;

	uart_pin_strap_config i_dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.clear_to_send_a_n(modem_n[0]), .clear_to_send_b_n(modem_n[1]),
		.set_ready_a_n(modem_n[2]), .set_ready_b_n(modem_n[3]),
		.carrier_detect_a_n(modem_n[4]), .carrier_detect_b_n(modem_n[5]),
		.ring_indicate_a_n(modem_n[6]), .ring_indicate_b_n(modem_n[7]),
		.serial_in_a(serial_in[0]), .serial_in_b(serial_in[1]),
		.request_send_a_n_i(pin_lvl[0]), .request_send_a_n_o(pin_o[0]),
		.request_send_a_n_oe(pin_oe[0]), .request_send_b_n_i(pin_lvl[1]),
		.request_send_b_n_o(pin_o[1]), .request_send_b_n_oe(pin_oe[1]),
		.terminal_ready_a_n_i(pin_lvl[2]), .terminal_ready_a_n_o(pin_o[2]),
		.terminal_ready_a_n_oe(pin_oe[2]), .terminal_ready_b_n_o(dtr_b_o),
		.terminal_ready_b_n_oe(dtr_b_oe), .serial_out_a_i(pin_lvl[3]),
		.serial_out_a_o(pin_o[3]), .serial_out_a_oe(pin_oe[3]),
		.serial_out_b_i(pin_lvl[4]), .serial_out_b_o(pin_o[4]),
		.serial_out_b_oe(pin_oe[4]), .cfg_port_addr_sel(port_sel),
		.watchdog_enable(wdog_en), .watchdog_count(watchdog_count),
		.default_clear(def_clr), .keyboard_ctrl_enable_bit(kbc_en),
		.cfg_bit_six(bit_six));

	modem_model i_modem (
		.aclk(aclk), .asserted(asserted), .sin(sin), .pull_up(pull_up),
		.pin_o(pin_o), .pin_oe(pin_oe), .modem_n(modem_n),
		.serial_in(serial_in), .pin_lvl(pin_lvl));

	// 25 MHz clock
	always #20 aclk = ~aclk;

	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Address and data offered together, each released when taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		int n;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		// Error answers meet a late ready, so the held response is seen
		bready  <= (er == RESP_OKAY);
		n = 0;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			n++;
		end while (bvalid !== 1'b1 && n < 40);
		if (bready !== 1'b1) begin
			bready <= 1'b1;
			@(posedge aclk);
		end
		bready <= 1'b0;
		check(32'({bvalid, bresp}), 32'({1'b1, er}));
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			n++;
		end while (rvalid !== 1'b1 && n < 40);
		rready <= 1'b0;
		check(rdata, ed);
		check(32'({rvalid, rresp}), 32'({1'b1, er}));
	endtask : axi_read

	// Reset with a given set of strap pull-ups fitted
	task automatic do_reset(input logic [4:0] pu);
		@(posedge aclk);
		aresetn <= 1'b0;
		pull_up <= pu;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask : do_reset

	// Every strap high, low and mixed, with a reset in mid-run
	task automatic test_straps();
		logic [4:0]  pats [3] = '{5'h1F, 5'h00, 5'h15};
		logic [4:0]  p;
		logic [31:0] e;
		foreach (pats[i]) begin
			p = pats[i];
			do_reset(p);
			e = 32'({bit_six, kbc_en, def_clr, wdog_en, port_sel});
			check(e, 32'(p));
			e = p[1] ? 32'(`WDOG_LOAD) : 32'h00000000;
			check(32'(watchdog_count), e);
			axi_read(`OFF_WDC, e, RESP_OKAY);
			e = 32'(p[0]) << `GC26_PORT_BIT;
			axi_read(`OFF_GC26, e, RESP_OKAY);
			axi_read(`OFF_ACT, 32'(p[1]), RESP_OKAY);
			e = {25'h0, p[4], 3'h0, p[3], 1'b0, p[2]};
			axi_read(`OFF_GC24, e, RESP_OKAY);
		end
	endtask : test_straps

	// Modem lines on and off, change bits cleared by a read
	task automatic test_modem();
		asserted <= 8'h55;
		sin      <= 2'b01;
		repeat (8) @(posedge aclk);
		axi_read(`OFF_STS_A, 32'h1FB, RESP_OKAY);
		axi_read(`OFF_STS_A, 32'h1F0, RESP_OKAY);
		asserted <= 8'hAA;
		sin      <= 2'b10;
		repeat (8) @(posedge aclk);
		axi_read(`OFF_STS_A, 32'h00F, RESP_OKAY);
		axi_read(`OFF_STS_B, 32'h1FB, RESP_OKAY);
	endtask : test_modem

	// Handshake bits reach the pins inverted, serial out bit not; driven after reset
	task automatic test_ctrl();
		axi_write(`OFF_CTRL_A, 32'h03, 4'hF, RESP_OKAY);
		axi_write(`OFF_CTRL_B, 32'h02, 4'hF, RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(32'({dtr_b_o, pin_o, pin_oe}), 32'h41F);
		check(32'({dtr_b_oe, pin_oe}), 32'h3F);
		axi_write(`OFF_CTRL_A, 32'h11, 4'hF, RESP_OKAY);
		axi_write(`OFF_CTRL_B, 32'h01, 4'hF, RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(32'({dtr_b_o, pin_lvl}), 32'h00B);
		axi_read(`OFF_CTRL_A, 32'h11, RESP_OKAY);
	endtask : test_ctrl

	// Masked write and an unmapped address
	task automatic test_bus();
		axi_write(`OFF_GC24, 32'hA5, 4'hF, RESP_OKAY);
		axi_write(`OFF_GC24, 32'h5A, 4'h0, RESP_OKAY);
		axi_read(`OFF_GC24, 32'hA5, RESP_OKAY);
		axi_write(8'h40, 32'hFF, 4'hF, RESP_SLVERR);
		axi_read(8'h40, 32'h0, RESP_SLVERR);
	endtask : test_bus

	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	// Main sequence, all inputs set at time zero
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{asserted, sin, pull_up} = '0;
		test_straps();
		test_modem();
		test_ctrl();
		test_bus();
		tally_and_finish();
	end

	// Hang guard, well past the roughly 140 cycles needed
	initial begin
		repeat (4000) @(posedge aclk);
		n_fail++;
		tally_and_finish();
	end
endmodule : tb
